//--- logic/mdac_host_ctrl.sv
// host-side controller for a parallel-port multiplying dac: write and readback
// assumes the dac pins are wired directly; the bench resolves the data wire
// Overview of operation
// - the whole code moves as one parallel word per access, width as resolution
// - every write makes a falling and then a rising select edge
// - read/write high with select low is a readback request
// - readback only checks the loaded code and never changes it
// - stretch each access by wait states so pin timing holds
`timescale 1ns/1ps
`include "mdac_host_cfg.svh"
module mdac_host_ctrl #(
  parameter int CODE_W   = `CODE_WIDTH,
  parameter int LOW_CYC  = `SEL_LOW_CYC,
  parameter int HIGH_CYC = `SEL_HIGH_CYC,
  parameter int WAIT_CYC = 1
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              req_valid,
  input  wire logic              req_read,
  input  wire logic [CODE_W-1:0] req_code,
  output logic                   req_ready,
  output logic                   done_pulse,
  output logic      [CODE_W-1:0] rd_code,
  output logic                   rd_match,
  output logic                   sel_n,
  output logic                   rd_wr,
  output logic      [CODE_W-1:0] data_out,
  output logic                   data_oe,
  input  wire logic [CODE_W-1:0] data_in
);
  localparam int HOLD_CYC = LOW_CYC + WAIT_CYC;
  localparam int CNT_W    = 8;

  // refuse widths and counts that the pins or the 8-bit counter cannot serve
  if (CODE_W != 8 && CODE_W != 10 && CODE_W != 12) begin : g_bad_width
    $error("code width must be 8, 10 or 12");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 255 || HIGH_CYC < 1 || HIGH_CYC > 255) begin : g_bad_count
    $error("timing counts out of range");
  end

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'(n - 1);
  endfunction

  // last select-low cycle; the pin and result groups both act on it
  function automatic logic access_end(input mdac_host_pkg::host_state_e st,
                                      input logic [CNT_W-1:0]          cnt);
    access_end = (st == mdac_host_pkg::ST_LOW) && (cnt == '0);
  endfunction

  mdac_host_pkg::host_state_e state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              sel_n_ff, nxt_sel_n;
  logic              rd_wr_ff, nxt_rd_wr;
  logic              oe_ff, nxt_oe;
  logic [CODE_W-1:0] dout_ff, nxt_dout;
  logic [CODE_W-1:0] last_wr_ff, nxt_last_wr;
  logic [CODE_W-1:0] rd_code_ff, nxt_rd_code;
  logic              match_ff, nxt_match;
  logic              done_ff, nxt_done;
  logic [CODE_W-1:0] data_sync;

  // data pins come from another device, so sample through two flops
  mdac_pin_sync #(.WIDTH(CODE_W)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .pin_in   (data_in),
    .pin_sync (data_sync)
  );

  // sequencer: state and the shared down-counter
  // the counter is shared: select-low hold first, then the select-high gap
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      mdac_host_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_cnt   = '0;
          nxt_state = mdac_host_pkg::ST_SETUP;
        end
      end
      // one cycle of rd_wr/data settle before select falls
      mdac_host_pkg::ST_SETUP: begin
        nxt_cnt   = cnt_of(HOLD_CYC);
        nxt_state = mdac_host_pkg::ST_LOW;
      end
      mdac_host_pkg::ST_LOW: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_state = mdac_host_pkg::ST_RISE;
        end
      end
      mdac_host_pkg::ST_RISE: begin
        nxt_cnt   = cnt_of(HIGH_CYC);
        nxt_state = mdac_host_pkg::ST_GAP;
      end
      // gap keeps select high long enough before the next access
      mdac_host_pkg::ST_GAP: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_state = mdac_host_pkg::ST_IDLE;
        end
      end
      // a lost one-hot bit falls back to idle with the pins parked
      default: begin
        nxt_cnt   = '0;
        nxt_state = mdac_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= mdac_host_pkg::ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // pin group: select, direction and the write word
  always_comb begin
    nxt_sel_n = sel_n_ff;
    nxt_rd_wr = rd_wr_ff;
    nxt_oe    = oe_ff;
    nxt_dout  = dout_ff;
    unique case (state_ff)
      mdac_host_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_rd_wr = req_read;
          nxt_dout  = req_code;
          nxt_oe    = !req_read;
        end
      end
      mdac_host_pkg::ST_SETUP: begin
        nxt_sel_n = 1'b0;
      end
      mdac_host_pkg::ST_LOW: begin
        if (access_end(state_ff, cnt_ff)) begin
          nxt_sel_n = 1'b1;
        end
      end
      // data stays driven one cycle past the rising edge for hold
      mdac_host_pkg::ST_RISE: begin
        nxt_oe    = 1'b0;
        nxt_rd_wr = 1'b1;
      end
      mdac_host_pkg::ST_GAP: begin
        nxt_oe = 1'b0;
      end
      default: begin
        nxt_sel_n = 1'b1;
        nxt_rd_wr = 1'b1;
        nxt_oe    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_n_ff <= 1'b1;
      rd_wr_ff <= 1'b1;
      oe_ff    <= 1'b0;
      dout_ff  <= '0;
    end else begin
      sel_n_ff <= nxt_sel_n;
      rd_wr_ff <= nxt_rd_wr;
      oe_ff    <= nxt_oe;
      dout_ff  <= nxt_dout;
    end
  end

  // result group: last written word, readback and the end-of-access pulse
  // rd_match is a host-side verdict, so software need not keep the last code
  always_comb begin
    nxt_last_wr = last_wr_ff;
    nxt_rd_code = rd_code_ff;
    nxt_match   = match_ff;
    nxt_done    = (state_ff == mdac_host_pkg::ST_RISE);
    if (access_end(state_ff, cnt_ff)) begin
      if (rd_wr_ff) begin
        // sync lags two cycles; select low long enough by wait states
        nxt_rd_code = data_sync;
        nxt_match   = (data_sync == last_wr_ff);
      end else begin
        nxt_last_wr = dout_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      last_wr_ff <= '0;
      rd_code_ff <= '0;
      match_ff   <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      last_wr_ff <= nxt_last_wr;
      rd_code_ff <= nxt_rd_code;
      match_ff   <= nxt_match;
      done_ff    <= nxt_done;
    end
  end

  assign req_ready  = (state_ff == mdac_host_pkg::ST_IDLE);
  assign done_pulse = done_ff;
  assign rd_code    = rd_code_ff;
  assign rd_match   = match_ff;
  assign sel_n      = sel_n_ff;
  assign rd_wr      = rd_wr_ff;
  assign data_out   = dout_ff;
  assign data_oe    = oe_ff;
endmodule

//--- logic/mdac_host_cfg.svh
// timing and field constants for the parallel multiplying-dac host controller
// assumes a 200 mhz clk; pin timing counts are derived from ns figures
`ifndef MDAC_HOST_CFG_SVH
`define MDAC_HOST_CFG_SVH
`define CLK_PERIOD_NS   5
// least select-low time per access, ns
`define SEL_LOW_NS      17
// least select-high time between accesses, ns
`define SEL_HIGH_NS     10
// least setup of data before select rises on a write, ns
`define TURN_NS         5
`define SEL_LOW_CYC     ((`SEL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_HIGH_CYC    ((`SEL_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TURN_CYC        ((`TURN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CODE_WIDTH      12
`endif

//--- logic/mdac_host_pkg.sv
// types shared by the parallel multiplying-dac host controller
// no assumptions beyond a single clock domain
package mdac_host_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_SETUP = 5'b0_0010,
    ST_LOW   = 5'b0_0100,
    ST_RISE  = 5'b0_1000,
    ST_GAP   = 5'b1_0000
  } host_state_e;
endpackage

//--- logic/mdac_pin_sync.sv
// two-flop synchroniser for a bus of pin inputs
// assumes the pins are quasi-static while sampled
`timescale 1ns/1ps
module mdac_pin_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = rstn ? pin_in : '0;
    nxt_sync = rstn ? meta_ff : '0;
  end

  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign pin_sync = sync_ff;
endmodule

//--- verif/mdac_dev_model.sv
// behavioural parallel-port dac: holding register, dac register, readback
// assumes the bench resolves the shared data wire from both enables
`timescale 1ns/1ps
module mdac_dev_model #(
  parameter int W = 12
) (
  input  wire logic         sel_n,
  input  wire logic         rd_wr,
  input  wire logic [W-1:0] bus,
  output logic      [W-1:0] dev_data,
  output logic              dev_oe,
  output logic      [W-1:0] dac
);
  logic [W-1:0] hold  = '0;
  logic [W-1:0] dac_q = '0;
  always @* if (!sel_n && !rd_wr) hold = bus;
  // latched, never transparent: only the rising select edge commits
  always @(posedge sel_n) if (!rd_wr) dac_q <= hold;
  assign dac      = dac_q;
  assign dev_oe   = !sel_n && rd_wr;
  assign dev_data = dac_q;
endmodule

//--- verif/mdac_host_ctrl_sva.sv
// pin-protocol checker for the host controller
// assumes default timing parameters of the controller
`timescale 1ns/1ps
module mdac_host_chk #(
  parameter int CODE_W = 12
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              sel_n,
  input wire logic              rd_wr,
  input wire logic              data_oe,
  input wire logic [CODE_W-1:0] data_out,
  input wire logic              done_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sel_edges_a: assert property ($fell(sel_n) |-> !sel_n[*5] ##1 sel_n)
    else $error("select low time wrong");
  mode_hold_a: assert property (!sel_n |-> $stable(rd_wr))
    else $error("rd_wr moved in access");
  word_hold_a: assert property (!sel_n && !rd_wr |-> data_oe && $stable(data_out))
    else $error("write word unstable");
  read_quiet_a: assert property (rd_wr |-> !data_oe)
    else $error("host drives on read");
  done_time_a: assert property ($rose(sel_n) |=> done_pulse)
    else $error("done late");
  c_wr: cover property ($fell(sel_n) && !rd_wr);
  c_rd: cover property ($fell(sel_n) && rd_wr);
  c_dn: cover property (done_pulse);
endmodule
bind mdac_host_ctrl mdac_host_chk #(.CODE_W(CODE_W)) chk (.clk(clk), .rstn(rstn),
  .sel_n(sel_n), .rd_wr(rd_wr), .data_oe(data_oe), .data_out(data_out),
  .done_pulse(done_pulse));

//--- verif/mdac_parallel_write_readback_port_test.sv
// self-checking bench: host controller against the dac model
// assumes default controller parameters and a 12-bit code
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module mdac_parallel_write_readback_port_test;
  logic        clk = 0, rstn = 0, req_valid = 0, req_read = 0;
  logic [11:0] req_code = '0, last_q = '0;
  wire         req_ready, done_pulse, rd_match, sel_n, rd_wr, data_oe, dev_oe;
  wire  [11:0] rd_code, data_out, dev_data, dac, bus;
  int          fail_count = 0, checks = 0;
  // no pull on the bus: an undriven wire toggles so stale data never passes
  assign bus = (data_oe === 1'b1) ? data_out : (dev_oe === 1'b1) ? dev_data : ~last_q;
  always @(posedge clk) last_q <= bus;
  initial forever #2.5 clk = ~clk;
  mdac_host_ctrl dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_read(req_read),
    .req_code(req_code), .req_ready(req_ready), .done_pulse(done_pulse), .rd_code(rd_code),
    .rd_match(rd_match), .sel_n(sel_n), .rd_wr(rd_wr), .data_out(data_out),
    .data_oe(data_oe), .data_in(bus));
  mdac_dev_model dev (.sel_n(sel_n), .rd_wr(rd_wr), .bus(bus), .dev_data(dev_data),
    .dev_oe(dev_oe), .dac(dac));
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic op(input logic rd, input logic [11:0] c);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
    if (req_ready !== 1'b1) begin fail_count++; end_of_test; end
    @(posedge clk);
    req_valid <= 1'b1;
    req_read  <= rd;
    req_code  <= c;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (done_pulse !== 1'b1 && n < 50);
    if (done_pulse !== 1'b1) begin fail_count++; end_of_test; end
    `CHK(req_ready, 1'b0)
  endtask
  task automatic t_wr(input logic [11:0] c);
    op(1'b0, c);
    `CHK(dac, c)
  endtask
  task automatic t_rd(input logic [11:0] c);
    op(1'b1, 12'h0000);
    `CHK(rd_code, c)
    `CHK(rd_match, 1'b1)
    `CHK(dac, c)
  endtask
  // a request right after done lands while busy and must be dropped
  task automatic t_refuse(input logic [11:0] c);
    t_wr(c);
    @(posedge clk);
    req_valid <= 1'b1;
    req_read  <= 1'b0;
    req_code  <= ~c;
    @(posedge clk);
    req_valid <= 1'b0;
    t_rd(c);
  endtask
  // mid-run reset: outputs park, then readback sees a dac that reset left alone
  task automatic t_reset(input logic [11:0] c);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK({sel_n, rd_wr, data_oe, done_pulse}, 4'hc)
    `CHK({rd_code, rd_match}, 13'h0000)
    op(1'b1, 12'h0000);
    `CHK(rd_code, c)
    `CHK(rd_match, 1'b0)
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_rd(12'h0000);
    t_wr(12'h0fff);
    t_rd(12'h0fff);
    t_wr(12'h0a5a);
    t_wr(12'h05a5);
    t_rd(12'h05a5);
    t_refuse(12'h0001);
    t_reset(12'h0001);
    end_of_test;
  end
endmodule
